// *** rtl/watchdog_params.svh ***
// watchdog_params.svh: offsets-free constants for the runaway watchdog
// assumes: included by the watchdog design files only
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH
`define WDOG_WIDTH 15
`define WDOG_RELOAD 15'h7fff
`define WDOG_PRESCALE 16
`define WDOG_SWRST_BIT 3
`define WDOG_MAX_PRIO 3'h7
`endif

// *** rtl/watchdog_pkg.sv ***
// watchdog_pkg: types shared by the runaway watchdog
// assumes: compiled before the design modules
package watchdog_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } wdog_state_t;
endpackage

// *** rtl/tick_divider.sv ***
// tick_divider: one-cycle count enable every div cycles of clk
// assumes: single clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
    parameter int DIV = 16
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } div_state_t;
    div_state_t cur;
    div_state_t next_cur;
    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (cur.cnt == 16'(DIV - 1)) begin
            next_cur.cnt = 16'h0000;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.cnt = cur.cnt + 16'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    assign tick = cur.tick;
endmodule
`default_nettype wire

// *** rtl/watchdog_runaway_detector.sv ***
// watchdog_runaway_detector: 15-bit runaway watchdog with software reset
// assumes: cpu write strobes on clk; cpu takes nmi, priority and reset here
// the cpu keeps its own priority level; this block only never resets it
// How it works
// - 15-bit down counter; underflow raises interrupt
// - interrupt is non-maskable, ignores enable/priority
// - stopped after reset until first start write
// - each start write loads 7fff, data ignored; a software reset in the same write wins
// - writing 1 to mode bit 3 resets
// - reset sequence starts at once, halts cpu
// - software reset keeps internal ram contents
// - vector jump is no reset; priority stays 7
`include "watchdog_params.svh"
`timescale 1ns/100ps
`default_nettype none
module watchdog_runaway_detector #(
    parameter int PRESCALE = `WDOG_PRESCALE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic startWrite,
    input wire logic modeWrite,
    input wire logic [7:0] modeData,
    input wire logic [2:0] processor_priority_level,
    input wire logic interruptEnable,
    output logic nmiRequest,
    output logic softReset,
    output logic ramHold,
    output logic [14:0] count,
    output logic running
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        watchdog_pkg::wdog_state_t st;
        logic [14:0] cnt;
        logic nmi;
        logic swrst;
        logic hold;
        logic run;
    } wd_t;
    wd_t cur;
    wd_t next_cur;
    logic tick;
    tick_divider #(.DIV(PRESCALE)) u_div (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // shared by the next-state logic and the checks below
    function automatic logic soft_reset_hit(input logic wr,
        input logic [7:0] data);
        return wr && data[`WDOG_SWRST_BIT];
    endfunction
    logic swrstReq;
    logic underflowNow;
    assign swrstReq = soft_reset_hit(modeWrite, modeData);
    // antecedent helper: cycles with a same-cycle start write or any mode write are left out
    assign underflowNow = running && tick && count == 15'h0000
        && !startWrite && !modeWrite;
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // the enable flag and priority inputs are deliberately unused in the
    // nmi path: a runaway program may have masked everything
    always_comb begin
        next_cur = cur;
        next_cur.nmi = 1'b0;
        next_cur.swrst = 1'b0;
        next_cur.hold = 1'b0;
        case (cur.st)
            watchdog_pkg::ST_IDLE: begin
                if (startWrite) begin
                    next_cur.st = watchdog_pkg::ST_RUN;
                    next_cur.run = 1'b1;
                    next_cur.cnt = `WDOG_RELOAD;
                end
            end
            watchdog_pkg::ST_RUN: begin
                if (startWrite) begin
                    next_cur.cnt = `WDOG_RELOAD;
                end else if (tick) begin
                    if (cur.cnt == 15'h0000) begin
                        next_cur.nmi = 1'b1;
                        // the nmi is no reset: keep running from the top
                        next_cur.cnt = `WDOG_RELOAD;
                    end else begin
                        next_cur.cnt = cur.cnt - 15'h0001;
                    end
                end
            end
            default: begin
                next_cur.st = watchdog_pkg::ST_IDLE;
                next_cur.run = 1'b0;
            end
        endcase
        // software reset wins over a start write or an underflow in the
        // same cycle: nothing may follow the reset, not even the nmi
        if (swrstReq) begin
            next_cur.swrst = 1'b1;
            next_cur.hold = 1'b1;
            next_cur.nmi = 1'b0;
            next_cur.st = watchdog_pkg::ST_IDLE;
            next_cur.run = 1'b0;
            next_cur.cnt = 15'h0000;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cur.st <= watchdog_pkg::ST_IDLE;
            cur.cnt <= 15'h0000;
            cur.nmi <= 1'b0;
            cur.swrst <= 1'b0;
            cur.hold <= 1'b0;
            cur.run <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end
    assign nmiRequest = cur.nmi;
    assign softReset = cur.swrst;
    assign ramHold = cur.hold;
    assign count = cur.cnt;
    assign running = cur.run;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_underflow;
        @(posedge clk) disable iff (rst)
        (running && tick && count == 15'h0000 && !startWrite && !modeWrite)
            |=> nmiRequest;
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("no nmi after underflow");
    property p_nomask;
        @(posedge clk) disable iff (rst)
        (running && tick && count == 15'h0000 && !startWrite && !modeWrite
            && !interruptEnable) |=> nmiRequest;
    endproperty
    a_nomask: assert property (p_nomask)
        else $error("nmi suppressed by mask");
    property p_idle;
        @(posedge clk) disable iff (rst)
        (!running && !startWrite) |=> (!running && !nmiRequest);
    endproperty
    a_idle: assert property (p_idle)
        else $error("counter left idle without start");
    property p_reload;
        @(posedge clk) disable iff (rst)
        (startWrite && !modeWrite) |=> (count == 15'h7fff && running);
    endproperty
    a_reload: assert property (p_reload)
        else $error("start write did not load 7fff");
    property p_swrst;
        @(posedge clk) disable iff (rst)
        swrstReq |=> (softReset && ramHold && !running);
    endproperty
    a_swrst: assert property (p_swrst)
        else $error("software reset not raised");
    property p_swrst_only;
        @(posedge clk) disable iff (rst)
        softReset |-> $past(swrstReq);
    endproperty
    a_swrst_only: assert property (p_swrst_only)
        else $error("spurious software reset");
    property p_dec;
        @(posedge clk) disable iff (rst)
        (running && tick && count != 15'h0000 && !startWrite && !modeWrite)
            |=> (count == $past(count) - 15'h0001);
    endproperty
    a_dec: assert property (p_dec)
        else $error("counter did not decrement");
    property p_hold;
        @(posedge clk) disable iff (rst)
        softReset |-> ramHold;
    endproperty
    a_hold: assert property (p_hold)
        else $error("ram hold missing on software reset");
    property p_hold_only;
        @(posedge clk) disable iff (rst)
        ramHold |-> softReset;
    endproperty
    a_hold_only: assert property (p_hold_only)
        else $error("ram hold without software reset");
    property p_nmi_noreset;
        @(posedge clk) disable iff (rst)
        nmiRequest |-> (running && !softReset && !ramHold);
    endproperty
    a_nmi_noreset: assert property (p_nmi_noreset)
        else $error("nmi acted as a reset");
    property p_prio_masked;
        @(posedge clk) disable iff (rst)
        (underflowNow && processor_priority_level == `WDOG_MAX_PRIO)
            |=> nmiRequest;
    endproperty
    a_prio_masked: assert property (p_prio_masked)
        else $error("nmi suppressed by priority level");
    property p_idle_frozen;
        @(posedge clk) disable iff (rst)
        (!running && !startWrite) |=> $stable(count);
    endproperty
    a_idle_frozen: assert property (p_idle_frozen)
        else $error("counter moved while idle");
    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    c_start: cover property (@(posedge clk) disable iff (rst)
        startWrite ##1 running);
    c_nmi: cover property (@(posedge clk) disable iff (rst) nmiRequest);
    c_swrst: cover property (@(posedge clk) disable iff (rst) softReset);
    c_kick: cover property (@(posedge clk) disable iff (rst)
        running && startWrite ##1 count == 15'h7fff);
    c_swrst_run: cover property (@(posedge clk) disable iff (rst)
        running && swrstReq);
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// tb_top: self-checking bench for the runaway watchdog
// assumes: design files compiled first; prescale shortened to 2
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    // ---------------------------------------------------------------
    // design and stimulus
    // ---------------------------------------------------------------
    localparam int PRE = 2;
    logic clk = 1'b0, rst = 1'b1, startWrite = 1'b0, modeWrite = 1'b0;
    logic [7:0] modeData = 8'h00;
    logic [2:0] processor_priority_level = 3'h7;
    logic interruptEnable = 1'b0;
    logic nmiRequest, softReset, ramHold, running;
    logic [14:0] count;
    int fail_count = 0, n_checks = 0, seed = 67, gap = 0, i;
    int prevCount = 0, prevRun = 0, reloadPending = 0, haveGap = 0;
    int masked = 0, wantNmi = 0;
    watchdog_runaway_detector #(.PRESCALE(PRE)) u_dut (.clk(clk),
        .rst(rst), .startWrite(startWrite), .modeWrite(modeWrite),
        .modeData(modeData),
        .processor_priority_level(processor_priority_level),
        .interruptEnable(interruptEnable), .nmiRequest(nmiRequest),
        .softReset(softReset), .ramHold(ramHold), .count(count),
        .running(running));
    initial begin
        forever #2 clk = ~clk;
    end
    // cpu state wanders freely: the nmi must not care
    // near the underflow everything is masked so the mask checks see it
    always @(posedge clk) begin
        if (masked != 0) begin
            processor_priority_level <= 3'h7;
            interruptEnable <= 1'b0;
        end else begin
            processor_priority_level <= 3'($random(seed));
            interruptEnable <= 1'($random(seed));
        end
    end
    // ---------------------------------------------------------------
    // behavioural model, checked at every settled cycle
    // ---------------------------------------------------------------
    always @(negedge clk) begin
        if (!rst) begin
            wantNmi = int'(prevRun != 0 && prevCount == 0
                && count == 15'h7fff && reloadPending == 0);
            `CHK(nmiRequest, 1'(wantNmi))
            if (running === 1'b1 && prevRun != 0) begin
                gap++;
                if (reloadPending != 0) begin
                    haveGap = 0;
                end else if (int'(count) != prevCount) begin
                    if (prevCount != 0) begin
                        `CHK(int'(count), prevCount - 1)
                    end
                    if (haveGap != 0) begin
                        `CHK(gap, PRE)
                    end
                    haveGap = 1;
                    gap = 0;
                end
            end else begin
                gap = 0;
                haveGap = 0;
            end
            prevCount = int'(count);
            prevRun = int'(running);
            reloadPending = int'(startWrite);
        end
    end
    // ---------------------------------------------------------------
    // tasks and run
    // ---------------------------------------------------------------
    task automatic pulse(input logic s, input logic m, input logic [7:0] d);
        @(posedge clk);
        startWrite <= s;
        modeWrite <= m;
        modeData <= d;
        @(posedge clk);
        startWrite <= 1'b0;
        modeWrite <= 1'b0;
        @(negedge clk);
    endtask
    task automatic close_out();
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #360000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(negedge clk);
        `CHK({running, count}, 16'h0000)
        pulse(1'b0, 1'b1, 8'hf7 & 8'($random(seed)));
        `CHK({running, softReset}, 2'b00)
        for (i = 0; i < 3; i++) begin
            pulse(1'b1, 1'b0, 8'($random(seed)));
            `CHK({running, count}, 16'hffff)
            repeat (7 * i + 3) @(negedge clk);
            `CHK(count < 15'h7fff, 1'b1)
        end
        pulse(1'b0, 1'b1, 8'hf7 & 8'($random(seed)));
        `CHK({running, softReset, ramHold}, 3'b100)
        masked = 1;
        for (i = 0; i < 70000 && nmiRequest !== 1'b1; i++) @(negedge clk);
        `CHK({nmiRequest, running, count}, 17'h1ffff)
        @(negedge clk);
        `CHK(nmiRequest, 1'b0)
        pulse(1'b1, 1'b1, 8'h08 | 8'($random(seed)));
        `CHK({softReset, ramHold, running, count}, 18'h30000)
        @(negedge clk);
        `CHK({softReset, ramHold, running}, 3'b000)
        close_out();
    end
endmodule
`default_nettype wire
